// >>> hdl/cpdiv_pkg.sv
// Package with mode codes, field positions and widths for the divider coprocessor.
package cpdiv_pkg;
  localparam int DATA_W   = 16;
  localparam int WORD_W   = 32;
  localparam int MODE_W   = 8;
  localparam int FLAG_W   = 4;
  localparam int OP_LSB   = 0;
  localparam int OP_MSB   = 3;
  localparam int SEL_LSB  = 4;
  localparam int SEL_MSB  = 5;
  localparam int HI_LSB   = 16;
  localparam int HI_MSB   = 31;
  localparam int LO_MSB   = 15;
  localparam int SIGN_BIT = 31;
  localparam int STEP_CNT = 32;
  localparam logic [3:0] OP_INIT2 = 4'h2;
  localparam logic [3:0] OP_READ  = 4'h3;
  localparam logic [3:0] OP_UDIV  = 4'h8;
  localparam logic [3:0] OP_SDIV  = 4'h9;
  localparam logic [1:0] SEL_Q_LO = 2'h0;
  localparam logic [1:0] SEL_Q_HI = 2'h1;
  localparam logic [1:0] SEL_R_LO = 2'h2;
  localparam logic [1:0] SEL_R_HI = 2'h3;
  localparam logic [7:0] MODE_LOAD  = 8'h02;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [31:0] RES_RESET = 32'h00000000;
  localparam logic [3:0] FLAGS_CLEAR = 4'h0;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_ONE  = 6'h01;
  typedef enum logic [1:0] {
    CPDIV_IDLE = 2'b00,
    CPDIV_RUN  = 2'b01,
    CPDIV_FIX  = 2'b10,
    CPDIV_DONE = 2'b11
  } cpdiv_state_e;
endpackage

// >>> hdl/cpdiv_if.sv
// Interface joining the host core and the divider coprocessor.
`timescale 1ns/1ps
interface cpdiv_if;
  logic        mode_set_transfer;
  logic        load_transfer;
  logic        operate_transfer;
  logic [7:0]  mode_val;
  logic [15:0] arg_first;
  logic [15:0] arg_second;
  logic        busy;
  logic        done;
  logic [15:0] result_half;
  logic [3:0]  condition_flag_set;

  modport core
  (
    output mode_set_transfer, load_transfer, operate_transfer, mode_val, arg_first, arg_second,
    input  busy, done, result_half, condition_flag_set
  );
  modport copro
  (
    input  mode_set_transfer, load_transfer, operate_transfer, mode_val, arg_first, arg_second,
    output busy, done, result_half, condition_flag_set
  );
endinterface

// >>> hdl/cpdiv_muldiv_coprocessor.sv
// Divider end: mode register, result registers and a restoring divider.
`timescale 1ns/1ps
module cpdiv_muldiv_coprocessor
(
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Link to the core.
  cpdiv_if.copro    cp
);
  logic [7:0]                mode_ff;
  logic [31:0]               result_register_zero_ff;
  logic [31:0]               result_register_one_ff;
  logic [31:0]               dvd_ff;
  logic [31:0]               dvs_ff;
  logic [31:0]               rem_ff;
  logic [5:0]                cnt_ff;
  logic                      neg_q_ff;
  logic                      neg_r_ff;
  logic [15:0]               half_ff;
  logic                      done_ff;
  cpdiv_pkg::cpdiv_state_e   state_ff;

  wire [3:0]  op_nib   = mode_ff[cpdiv_pkg::OP_MSB:cpdiv_pkg::OP_LSB];
  wire [1:0]  sel_nib  = mode_ff[cpdiv_pkg::SEL_MSB:cpdiv_pkg::SEL_LSB];
  wire        is_div   = (op_nib == cpdiv_pkg::OP_UDIV) || (op_nib == cpdiv_pkg::OP_SDIV);
  wire        is_sdiv  = (op_nib == cpdiv_pkg::OP_SDIV);
  wire        idle     = (state_ff == cpdiv_pkg::CPDIV_IDLE);
  // The divisor is the first operand above the second one.
  wire [31:0] divisor  = {cp.arg_first, cp.arg_second};
  wire        dvd_neg  = is_sdiv && result_register_zero_ff[cpdiv_pkg::SIGN_BIT];
  wire        dvs_neg  = is_sdiv && divisor[cpdiv_pkg::SIGN_BIT];
  wire [31:0] dvd_mag  = dvd_neg ? (~result_register_zero_ff + 32'h00000001) : result_register_zero_ff;
  wire [31:0] dvs_mag  = dvs_neg ? (~divisor + 32'h00000001) : divisor;
  wire        start    = idle && cp.operate_transfer && is_div;
  wire        rd_req   = idle && cp.operate_transfer && (op_nib == cpdiv_pkg::OP_READ);
  wire        ld_req   = idle && cp.load_transfer && (op_nib == cpdiv_pkg::OP_INIT2);
  // One restoring step: shift in the next dividend bit and try to subtract.
  wire [32:0] trial    = {rem_ff, dvd_ff[cpdiv_pkg::SIGN_BIT]} - {1'b0, dvs_ff};
  wire        fits     = ~trial[32];
  wire [31:0] rem_next = fits ? trial[31:0] : {rem_ff[30:0], dvd_ff[cpdiv_pkg::SIGN_BIT]};
  wire [31:0] q_fix    = neg_q_ff ? (~dvd_ff + 32'h00000001) : dvd_ff;
  wire [31:0] r_fix    = neg_r_ff ? (~rem_ff + 32'h00000001) : rem_ff;
  wire        last     = (cnt_ff == cpdiv_pkg::CNT_ONE);

  // Half selection reads the stored registers, so read mode and divide share one path.
  wire [15:0] q_lo     = result_register_zero_ff[cpdiv_pkg::LO_MSB:0];
  wire [15:0] q_hi     = result_register_zero_ff[cpdiv_pkg::HI_MSB:cpdiv_pkg::HI_LSB];
  wire [15:0] r_lo     = result_register_one_ff[cpdiv_pkg::LO_MSB:0];
  wire [15:0] r_hi     = result_register_one_ff[cpdiv_pkg::HI_MSB:cpdiv_pkg::HI_LSB];
  wire [15:0] picked   = (sel_nib == cpdiv_pkg::SEL_Q_LO) ? q_lo
                       : (sel_nib == cpdiv_pkg::SEL_Q_HI) ? q_hi
                       : (sel_nib == cpdiv_pkg::SEL_R_LO) ? r_lo
                       : r_hi;

  wire        in_run   = (state_ff == cpdiv_pkg::CPDIV_RUN);
  wire        in_fix   = (state_ff == cpdiv_pkg::CPDIV_FIX);
  wire        in_done  = (state_ff == cpdiv_pkg::CPDIV_DONE);
  wire        answer   = rd_req || in_done;

  assign cp.busy               = !idle;
  assign cp.done               = done_ff;
  assign cp.result_half        = half_ff;
  assign cp.condition_flag_set = cpdiv_pkg::FLAGS_CLEAR;

  // Result registers change only on a load or a finished divide, so a read or a
  // reserved code leaves them alone.
  wire [7:0]  nxt_mode  = (idle && cp.mode_set_transfer) ? cp.mode_val : mode_ff;
  wire [31:0] nxt_result_register_zero  = ld_req ? {cp.arg_first, cp.arg_second}
                        : in_fix ? q_fix
                        : result_register_zero_ff;
  wire [31:0] nxt_result_register_one  = in_fix ? r_fix : result_register_one_ff;
  wire [31:0] nxt_dvd   = start ? dvd_mag
                        : in_run ? {dvd_ff[30:0], fits} : dvd_ff;
  wire [31:0] nxt_dvs   = start ? dvs_mag : dvs_ff;
  wire [31:0] nxt_rem   = start ? cpdiv_pkg::RES_RESET
                        : in_run ? rem_next : rem_ff;
  wire [5:0]  nxt_cnt   = start ? 6'(cpdiv_pkg::STEP_CNT)
                        : in_run ? (cnt_ff - cpdiv_pkg::CNT_ONE) : cnt_ff;
  wire        nxt_neg_q = start ? (dvd_neg ^ dvs_neg) : neg_q_ff;
  wire        nxt_neg_r = start ? dvd_neg : neg_r_ff;
  wire        nxt_done  = answer;
  wire [15:0] nxt_half  = answer ? picked : half_ff;

  // A divide runs its steps, spends one cycle storing and one answering.
  cpdiv_pkg::cpdiv_state_e nxt_state;
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      cpdiv_pkg::CPDIV_IDLE:
        if (start)
          nxt_state = cpdiv_pkg::CPDIV_RUN;
      cpdiv_pkg::CPDIV_RUN:
        if (last)
          nxt_state = cpdiv_pkg::CPDIV_FIX;
      cpdiv_pkg::CPDIV_FIX:
        nxt_state = cpdiv_pkg::CPDIV_DONE;
      cpdiv_pkg::CPDIV_DONE:
        nxt_state = cpdiv_pkg::CPDIV_IDLE;
      default:
        nxt_state = cpdiv_pkg::CPDIV_IDLE;
    endcase
  end

  // Mode writes are ignored while busy, so a running divide keeps its output half.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mode_ff <= cpdiv_pkg::MODE_RESET;
    else
      mode_ff <= nxt_mode;
  end

  // The quotient overwrites the dividend, so a second divide needs a fresh load.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      result_register_zero_ff <= cpdiv_pkg::RES_RESET;
    else
      result_register_zero_ff <= nxt_result_register_zero;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      result_register_one_ff <= cpdiv_pkg::RES_RESET;
    else
      result_register_one_ff <= nxt_result_register_one;
  end

  // A divide takes a fixed number of cycles, whatever the operands are.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= cpdiv_pkg::CPDIV_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      dvd_ff <= cpdiv_pkg::RES_RESET;
    else
      dvd_ff <= nxt_dvd;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      dvs_ff <= cpdiv_pkg::RES_RESET;
    else
      dvs_ff <= nxt_dvs;
  end

  // The partial remainder starts at zero on every divide.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rem_ff <= cpdiv_pkg::RES_RESET;
    else
      rem_ff <= nxt_rem;
  end

  // The step counter runs down to one, which marks the last step.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= cpdiv_pkg::CNT_ZERO;
    else
      cnt_ff <= nxt_cnt;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      neg_q_ff <= 1'b0;
    else
      neg_q_ff <= nxt_neg_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      neg_r_ff <= 1'b0;
    else
      neg_r_ff <= nxt_neg_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      done_ff <= 1'b0;
    else
      done_ff <= nxt_done;
  end

  // The answer half holds until the next answer, so the core may take it late.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      half_ff <= 16'(cpdiv_pkg::RES_RESET);
    else
      half_ff <= nxt_half;
  end
endmodule

// >>> hdl/cpdiv_host_core.sv
// Core end: sequences load, mode select and divide, takes the low quotient half, then reads the other three halves.
`timescale 1ns/1ps
module cpdiv_host_core
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // User request.
  input  wire logic        req,
  input  wire logic        signed_div,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  // User answer.
  output logic             busy,
  output logic             ack,
  output logic [31:0]      quotient,
  output logic [31:0]      remainder,
  output logic [3:0]       flags,
  // Link to the coprocessor.
  cpdiv_if.core            cp
);
  typedef enum logic [3:0] {
    CPHOST_IDLE = 4'b0000, CPHOST_MLD = 4'b0001, CPHOST_LD  = 4'b0010,
    CPHOST_MDV  = 4'b0011, CPHOST_OP  = 4'b0100, CPHOST_W   = 4'b0101,
    CPHOST_M1   = 4'b0110, CPHOST_R1  = 4'b0111, CPHOST_M2  = 4'b1000,
    CPHOST_R2   = 4'b1001, CPHOST_M3  = 4'b1010, CPHOST_R3  = 4'b1011,
    CPHOST_END  = 4'b1100
  } cpdiv_host_state_e;

  cpdiv_host_state_e state_ff;
  logic [31:0]   dvd_ff;
  logic [31:0]   dvs_ff;
  logic          sgn_ff;
  logic [31:0]   q_ff;
  logic [31:0]   r_ff;
  logic [3:0]    flags_ff;
  logic          ack_ff;

  wire [3:0] div_op   = sgn_ff ? cpdiv_pkg::OP_SDIV : cpdiv_pkg::OP_UDIV;
  wire       waiting  = (state_ff == CPHOST_W) || (state_ff == CPHOST_R1)
                     || (state_ff == CPHOST_R2) || (state_ff == CPHOST_R3);
  wire       got      = waiting && cp.done;

  // Mode codes for each step of the sequence.
  assign cp.mode_set_transfer = (state_ff == CPHOST_MLD) || (state_ff == CPHOST_MDV)
                             || (state_ff == CPHOST_M1) || (state_ff == CPHOST_M2)
                             || (state_ff == CPHOST_M3);
  assign cp.mode_val = (state_ff == CPHOST_MLD) ? cpdiv_pkg::MODE_LOAD
                     : (state_ff == CPHOST_MDV) ? {4'h0, div_op}
                     : (state_ff == CPHOST_M1)  ? {2'b00, cpdiv_pkg::SEL_Q_HI, cpdiv_pkg::OP_READ}
                     : (state_ff == CPHOST_M2)  ? {2'b00, cpdiv_pkg::SEL_R_LO, cpdiv_pkg::OP_READ}
                     : {2'b00, cpdiv_pkg::SEL_R_HI, cpdiv_pkg::OP_READ};
  assign cp.load_transfer    = (state_ff == CPHOST_LD);
  // Read-mode operands carry no meaning, the divide sends the divisor halves.
  assign cp.operate_transfer = (state_ff == CPHOST_OP)
                            || ((state_ff == CPHOST_R1 || state_ff == CPHOST_R2
                                 || state_ff == CPHOST_R3) && !cp.busy && !cp.done && !ack_ff);
  assign cp.arg_first  = (state_ff == CPHOST_LD) ? dvd_ff[31:16] : dvs_ff[31:16];
  assign cp.arg_second = (state_ff == CPHOST_LD) ? dvd_ff[15:0]  : dvs_ff[15:0];
  assign busy      = (state_ff != CPHOST_IDLE);
  assign ack       = ack_ff;
  assign quotient  = q_ff;
  assign remainder = r_ff;
  assign flags     = flags_ff;

  // ack_ff doubles as a one-shot so each read stage issues one operate transfer.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= CPHOST_IDLE;
      dvd_ff <= 32'h00000000;
      dvs_ff <= 32'h00000000;
      sgn_ff <= 1'b0;
      q_ff <= 32'h00000000;
      r_ff <= 32'h00000000;
      flags_ff <= 4'h0;
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= cp.operate_transfer;
      case (state_ff)
        CPHOST_IDLE: if (req)
        begin
          dvd_ff <= dividend;
          dvs_ff <= divisor;
          sgn_ff <= signed_div;
          state_ff <= CPHOST_MLD;
        end
        CPHOST_MLD: state_ff <= CPHOST_LD;
        CPHOST_LD:  state_ff <= CPHOST_MDV;
        CPHOST_MDV: state_ff <= CPHOST_OP;
        CPHOST_OP:  state_ff <= CPHOST_W;
        CPHOST_W: if (got)
        begin
          q_ff[15:0] <= cp.result_half;
          flags_ff <= cp.condition_flag_set;
          state_ff <= CPHOST_M1;
        end
        CPHOST_M1:  state_ff <= CPHOST_R1;
        CPHOST_R1: if (got)
        begin
          q_ff[31:16] <= cp.result_half;
          state_ff <= CPHOST_M2;
        end
        CPHOST_M2:  state_ff <= CPHOST_R2;
        CPHOST_R2: if (got)
        begin
          r_ff[15:0] <= cp.result_half;
          state_ff <= CPHOST_M3;
        end
        CPHOST_M3:  state_ff <= CPHOST_R3;
        CPHOST_R3: if (got)
        begin
          r_ff[31:16] <= cp.result_half;
          state_ff <= CPHOST_END;
        end
        CPHOST_END: state_ff <= CPHOST_IDLE;
        default:    state_ff <= CPHOST_IDLE;
      endcase
    end
  end
endmodule

// >>> dv/cpdiv_link_props.sv
// Checker for the link between the host core and the divider coprocessor.
`timescale 1ns/1ps
module cpdiv_link_props
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Link signals.
  input wire logic        mode_set_transfer,
  input wire logic        load_transfer,
  input wire logic        operate_transfer,
  input wire logic [7:0]  mode_val,
  input wire logic [15:0] arg_first,
  input wire logic [15:0] arg_second,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [15:0] result_half,
  input wire logic [3:0]  condition_flag_set
);
  logic        [7:0]  mode_ff;
  logic        [31:0] ld_ff;
  logic        [31:0] r_ff;
  wire         [31:0] dvs = {arg_first, arg_second};
  wire                sgn = mode_ff[3:0] == cpdiv_pkg::OP_SDIV;
  wire                div_op = operate_transfer && !busy &&
                               (sgn || mode_ff[3:0] == cpdiv_pkg::OP_UDIV);
  wire                rd_op = operate_transfer && !busy && mode_ff[3:0] == cpdiv_pkg::OP_READ;
  // Signed and unsigned quotients stay apart so neither sees the other's signedness.
  wire signed  [31:0] sq = $signed(ld_ff) / $signed(dvs);
  wire signed  [31:0] sr = $signed(ld_ff) % $signed(dvs);
  wire         [31:0] nxt_q = sgn ? sq : ld_ff / dvs;
  wire         [31:0] nxt_r = sgn ? sr : ld_ff % dvs;
  wire         [63:0] qr = {r_ff, ld_ff};
  wire         [15:0] half = qr[mode_ff[5:4]*16 +: 16];

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      mode_ff <= 8'h00;
      ld_ff   <= 32'h00000000;
      r_ff    <= 32'h00000000;
    end
    else
    begin
      if (mode_set_transfer && !busy)
        mode_ff <= mode_val;
      if (load_transfer && !busy && mode_ff[3:0] == cpdiv_pkg::OP_INIT2)
        ld_ff <= dvs;
      // The quotient replaces the dividend, as result register zero does.
      if (div_op)
        ld_ff <= nxt_q;
      if (div_op)
        r_ff <= nxt_r;
    end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_div_run;
    (busy && !done) [*8];
  endsequence
  sequence s_div_end;
    done && !busy;
  endsequence

  property p_div_busy; div_op |=> s_div_run; endproperty
  property p_div_done; div_op |-> ##35 s_div_end; endproperty
  property p_div_val; div_op && mode_ff != 8'h29 |-> ##35 result_half == half; endproperty
  property p_read_val; rd_op |=> s_div_end and result_half == half; endproperty
  property p_flags; done |-> condition_flag_set == cpdiv_pkg::FLAGS_CLEAR; endproperty
  property p_hold; $changed(result_half) |-> done; endproperty
  property p_host_wait; busy |-> !(mode_set_transfer || load_transfer || operate_transfer);
  endproperty
  property p_load_quiet; load_transfer && !busy |=> !done && !busy; endproperty

  a_div_busy: assert property (p_div_busy) else $error("busy missing after divide");
  a_div_done: assert property (p_div_done) else $error("divide done late");
  a_div_val: assert property (p_div_val) else $error("divide half wrong");
  a_read_val: assert property (p_read_val) else $error("read half wrong");
  a_flags: assert property (p_flags) else $error("flags not clear");
  a_hold: assert property (p_hold) else $error("result half moved");
  a_host_wait: assert property (p_host_wait) else $error("transfer while busy");
  a_load_quiet: assert property (p_load_quiet) else $error("load answered");
endmodule

// >>> dv/tb_coprocessor_divider.sv
// Self-checking bench: host core and divider joined over the link.
`timescale 1ns/1ps
module tb_coprocessor_divider;
  logic        clk_sys;
  logic        rst_n;
  logic        req;
  logic        signed_div;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        busy;
  logic        ack;
  logic [31:0] quotient;
  logic [31:0] remainder;
  logic [3:0]  flags;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          acks = 0;

  cpdiv_if u_cpdiv_if ();
  cpdiv_muldiv_coprocessor u_cpdiv_muldiv_coprocessor (.clk_sys(clk_sys), .rst_n(rst_n),
    .cp(u_cpdiv_if));
  cpdiv_host_core u_cpdiv_host_core (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .signed_div(signed_div), .dividend(dividend), .divisor(divisor), .busy(busy), .ack(ack),
    .quotient(quotient), .remainder(remainder), .flags(flags), .cp(u_cpdiv_if));
  cpdiv_link_props u_cpdiv_link_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .mode_set_transfer(u_cpdiv_if.mode_set_transfer), .load_transfer(u_cpdiv_if.load_transfer),
    .operate_transfer(u_cpdiv_if.operate_transfer), .mode_val(u_cpdiv_if.mode_val),
    .arg_first(u_cpdiv_if.arg_first), .arg_second(u_cpdiv_if.arg_second),
    .busy(u_cpdiv_if.busy), .done(u_cpdiv_if.done), .result_half(u_cpdiv_if.result_half),
    .condition_flag_set(u_cpdiv_if.condition_flag_set));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One full divide; the next call may start right after busy falls.
  task automatic run_div(input logic sg, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] eq;
    logic [31:0] er;
    int          n;
    int          a0;
    if (sg)
    begin
      eq = $signed(a) / $signed(b);
      er = $signed(a) % $signed(b);
    end
    else
    begin
      eq = a / b;
      er = a % b;
    end
    a0 = acks;
    @(negedge clk_sys);
    req = 1'b1;
    signed_div = sg;
    dividend = a;
    divisor = b;
    @(negedge clk_sys);
    req = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n < 200), 32'h00000001);
    check(quotient, eq);
    check(remainder, er);
    check({28'h0000000, flags}, 32'h00000000);
    check(32'(acks - a0), 32'h00000004);
  endtask

  // One divide and three reads each leave one acknowledge cycle.
  always @(negedge clk_sys)
    if (ack === 1'b1)
      acks++;

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Runs stop here if the link hangs.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    req = 1'b0;
    signed_div = 1'b0;
    dividend = 32'h00000000;
    divisor = 32'h00000000;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    run_div(1'b0, 32'h12345678, 32'h00010000);
    run_div(1'b0, 32'h00000064, 32'h00000007);
    run_div(1'b0, 32'hFFFFFFFF, 32'h00000010);
    run_div(1'b0, 32'h00000005, 32'hFFFFFFFF);
    run_div(1'b0, 32'h00000000, 32'h00000003);
    run_div(1'b1, 32'hFFFFFF9C, 32'h00000007);
    run_div(1'b1, 32'h00000064, 32'hFFFFFFF9);
    run_div(1'b1, 32'hFFFFFF9C, 32'hFFFFFFF9);
    run_div(1'b1, 32'h7FFFFFFF, 32'h00012345);
    tally_and_finish();
  end
endmodule
